//--- pit_regs.svh
`ifndef PIT_REGS_SVH
`define PIT_REGS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define PIT_NCH 4
`define PIT_NMT 2
`define PIT_CW 16
`define PIT_MW 8
`define PIT_DW 32
`define PIT_AW 8
`define PIT_BEW 4
`define PIT_BW 8

// ----------------------------------------------------------------
// byte offsets
// ----------------------------------------------------------------
`define PIT_OFF_CTRL 8'h00
`define PIT_OFF_CHEN 8'h04
`define PIT_OFF_MUX 8'h08
`define PIT_OFF_IRQEN 8'h0c
`define PIT_OFF_FLAG 8'h10
`define PIT_OFF_STAT 8'h14
`define PIT_OFF_MLD0 8'h18
`define PIT_OFF_LD0 8'h20
`define PIT_OFF_CNT0 8'h30
`define PIT_STRIDE 8'h04

// ----------------------------------------------------------------
// fields and values
// ----------------------------------------------------------------
`define PIT_CTRL_EN 0
`define PIT_CTRL_MFL 8
`define PIT_CTRL_CFL 16
`define PIT_STAT_MACT 0
`define PIT_STAT_CACT 8
`define PIT_RST_CNT 16'h0000
`define PIT_RST_MCNT 8'h00
`define PIT_RST_CH 4'h0
`define PIT_RST_WORD 32'h0000_0000
`define PIT_C1 16'h0001
`define PIT_M1 8'h01
`endif

//--- pit_pkg.sv
`default_nettype none
`include "pit_regs.svh"
package pit_pkg;
  typedef logic [`PIT_CW-1:0] pit_cnt_t;
  typedef logic [`PIT_MW-1:0] pit_mcnt_t;
  typedef logic [`PIT_NCH-1:0] pit_ch_t;
  typedef logic [`PIT_DW-1:0] pit_word_t;
  typedef enum logic {pit_bus_idle, pit_bus_ack} pit_bus_e;
endpackage : pit_pkg
`default_nettype wire

//--- pit_chan_ctr.sv
`default_nettype none
`include "pit_regs.svh"
module pit_chan_ctr import pit_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic act,
  input wire logic tick,
  input wire logic force_ld,
  input wire pit_cnt_t load_val,
  // state
  output pit_cnt_t cnt,
  output logic timeout
);

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  logic act_r;
  pit_cnt_t cnt_r;
  pit_cnt_t cnt_nxt;
  wire start = act & ~act_r;
  wire at_zero = (cnt_r == `PIT_RST_CNT);
  wire step = act & tick & ~force_ld & ~start;

  assign timeout = step & at_zero;
  assign cnt = cnt_r;

  always_comb begin
    if (force_ld || start) begin
      cnt_nxt = load_val;
    end else if (step && at_zero) begin
      cnt_nxt = load_val;
    end else if (step) begin
      cnt_nxt = cnt_r - `PIT_C1;
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= `PIT_RST_CNT;
      act_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      act_r <= act;
    end
  end

endmodule : pit_chan_ctr
`default_nettype wire

//--- pit_top.sv
// Local design decisions: the register offsets and the Avalon-MM register port.
`default_nettype none
`include "pit_regs.svh"
module pit_top import pit_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [`PIT_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [`PIT_DW-1:0] avs_writedata,
  input wire logic [`PIT_BEW-1:0] avs_byteenable,
  output logic [`PIT_DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupts
  output logic irq,
  output logic [`PIT_NCH-1:0] channel_irq,
  // hardware triggers
  output logic [`PIT_NCH-1:0] timeout_trigger_out
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_q1_r;
  logic rst_q2_r;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_q1_r <= 1'b0;
      rst_q2_r <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_q2_r <= rst_q1_r;
    end
  end

  // only the second flop feeds the rest of the design
  wire rst_n = rst_q2_r;

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  pit_bus_e bus_st_r;
  pit_bus_e bus_st_nxt;
  wire bus_req = avs_read | avs_write;
  wire bus_ack = (bus_st_r == pit_bus_ack);
  wire wr_go = avs_write & bus_ack;
  wire rd_cap = avs_read & ~bus_ack;

  // one wait state on every access
  assign avs_waitrequest = bus_req & ~bus_ack;

  always_comb begin
    case (bus_st_r)
      pit_bus_idle: begin
        bus_st_nxt = bus_req ? pit_bus_ack : pit_bus_idle;
      end
      pit_bus_ack: begin
        bus_st_nxt = pit_bus_idle;
      end
      default: begin
        bus_st_nxt = pit_bus_idle;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_st_r <= pit_bus_idle;
    end else begin
      bus_st_r <= bus_st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // byte lanes
  // ----------------------------------------------------------------
  pit_word_t be_mask;
  pit_word_t wdata_m;

  // lanes not enabled keep their old bits
  for (genvar b = 0; b < `PIT_BEW; b++) begin : g_lane
    assign be_mask[b*`PIT_BW +: `PIT_BW] = {`PIT_BW{avs_byteenable[b]}};
  end

  assign wdata_m = avs_writedata & be_mask;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // unaligned and unlisted addresses hit nothing
  wire hit_ctrl = (avs_address == `PIT_OFF_CTRL);
  wire hit_chen = (avs_address == `PIT_OFF_CHEN);
  wire hit_mux = (avs_address == `PIT_OFF_MUX);
  wire hit_irqen = (avs_address == `PIT_OFF_IRQEN);
  wire hit_flag = (avs_address == `PIT_OFF_FLAG);
  wire hit_stat = (avs_address == `PIT_OFF_STAT);
  logic [`PIT_NMT-1:0] hit_mld;
  logic [`PIT_NCH-1:0] hit_ld;
  logic [`PIT_NCH-1:0] hit_cnt;

  for (genvar j = 0; j < `PIT_NMT; j++) begin : g_hit_m
    assign hit_mld[j] = (avs_address == `PIT_OFF_MLD0 + 8'(j) * `PIT_STRIDE);
  end

  for (genvar i = 0; i < `PIT_NCH; i++) begin : g_hit_c
    assign hit_ld[i] = (avs_address == `PIT_OFF_LD0 + 8'(i) * `PIT_STRIDE);
    assign hit_cnt[i] = (avs_address == `PIT_OFF_CNT0 + 8'(i) * `PIT_STRIDE);
  end

  wire we_ctrl = wr_go & hit_ctrl;
  wire we_chen = wr_go & hit_chen;
  wire we_mux = wr_go & hit_mux;
  wire we_irqen = wr_go & hit_irqen;
  wire we_flag = wr_go & hit_flag;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic mod_en_r;
  pit_ch_t chan_en_r;
  pit_ch_t mux_r;
  pit_ch_t irqen_r;
  pit_mcnt_t mld_r [`PIT_NMT];
  pit_cnt_t ld_r [`PIT_NCH];

  pit_word_t ctrl_rd;
  pit_word_t chen_rd;
  pit_word_t mux_rd;
  pit_word_t irqen_rd;

  assign ctrl_rd = `PIT_DW'(mod_en_r);
  assign chen_rd = `PIT_DW'(chan_en_r);
  assign mux_rd = `PIT_DW'(mux_r);
  assign irqen_rd = `PIT_DW'(irqen_r);

  wire pit_word_t ctrl_mrg = (ctrl_rd & ~be_mask) | wdata_m;
  wire pit_word_t chen_mrg = (chen_rd & ~be_mask) | wdata_m;
  wire pit_word_t mux_mrg = (mux_rd & ~be_mask) | wdata_m;
  wire pit_word_t irqen_mrg = (irqen_rd & ~be_mask) | wdata_m;

  wire mod_en_nxt = we_ctrl ? ctrl_mrg[`PIT_CTRL_EN] : mod_en_r;
  wire pit_ch_t chan_en_nxt = we_chen ? chen_mrg[`PIT_NCH-1:0] : chan_en_r;
  wire pit_ch_t mux_nxt = we_mux ? mux_mrg[`PIT_NCH-1:0] : mux_r;
  wire pit_ch_t irqen_nxt = we_irqen ? irqen_mrg[`PIT_NCH-1:0] : irqen_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mod_en_r <= 1'b0;
      chan_en_r <= `PIT_RST_CH;
      mux_r <= `PIT_RST_CH;
      irqen_r <= `PIT_RST_CH;
    end else begin
      mod_en_r <= mod_en_nxt;
      chan_en_r <= chan_en_nxt;
      mux_r <= mux_nxt;
      irqen_r <= irqen_nxt;
    end
  end

  // ----------------------------------------------------------------
  // force loads
  // ----------------------------------------------------------------
  // force loads act even while disabled
  wire [`PIT_NMT-1:0] m_force_bits = wdata_m[`PIT_CTRL_MFL +: `PIT_NMT];
  wire pit_ch_t c_force_bits = wdata_m[`PIT_CTRL_CFL +: `PIT_NCH];
  wire [`PIT_NMT-1:0] m_force = {`PIT_NMT{we_ctrl}} & m_force_bits;
  wire pit_ch_t c_force = {`PIT_NCH{we_ctrl}} & c_force_bits;

  // ----------------------------------------------------------------
  // channel activity
  // ----------------------------------------------------------------
  wire pit_ch_t chan_act = {`PIT_NCH{mod_en_r}} & chan_en_r;
  wire pit_ch_t chan_act_nxt = {`PIT_NCH{mod_en_nxt}} & chan_en_nxt;

  // ----------------------------------------------------------------
  // micro timers
  // ----------------------------------------------------------------
  logic [`PIT_NMT-1:0] m_act;
  logic [`PIT_NMT-1:0] m_act_r;
  logic [`PIT_NMT-1:0] m_tick;
  pit_mcnt_t mcnt_r [`PIT_NMT];

  for (genvar j = 0; j < `PIT_NMT; j++) begin : g_micro
    pit_ch_t sel;
    pit_mcnt_t mld_mrg;
    pit_mcnt_t mcnt_nxt;
    wire m_start = m_act[j] & ~m_act_r[j];
    wire m_zero = (mcnt_r[j] == `PIT_RST_MCNT);

    for (genvar i = 0; i < `PIT_NCH; i++) begin : g_sel
      assign sel[i] = (mux_r[i] == 1'(j));
    end

    assign m_act[j] = |(sel & chan_act);
    assign m_tick[j] = m_act[j] & m_zero & ~m_force[j] & ~m_start;
    assign mld_mrg = (mld_r[j] & ~be_mask[`PIT_MW-1:0]) | wdata_m[`PIT_MW-1:0];

    always_comb begin
      if (m_force[j] || m_start) begin
        mcnt_nxt = mld_r[j];
      end else if (m_tick[j]) begin
        mcnt_nxt = mld_r[j];
      end else if (m_act[j]) begin
        mcnt_nxt = mcnt_r[j] - `PIT_M1;
      end else begin
        mcnt_nxt = mcnt_r[j];
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        mcnt_r[j] <= `PIT_RST_MCNT;
        mld_r[j] <= `PIT_RST_MCNT;
        m_act_r[j] <= 1'b0;
      end else begin
        mcnt_r[j] <= mcnt_nxt;
        m_act_r[j] <= m_act[j];
        if (wr_go && hit_mld[j]) begin
          mld_r[j] <= mld_mrg;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // channel counters
  // ----------------------------------------------------------------
  pit_cnt_t cnt_w [`PIT_NCH];
  pit_ch_t tout;

  for (genvar i = 0; i < `PIT_NCH; i++) begin : g_chan
    wire ch_tick = mux_r[i] ? m_tick[1] : m_tick[0];
    pit_cnt_t ld_mrg;

    assign ld_mrg = (ld_r[i] & ~be_mask[`PIT_CW-1:0]) | wdata_m[`PIT_CW-1:0];

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        ld_r[i] <= `PIT_RST_CNT;
      end else if (wr_go && hit_ld[i]) begin
        ld_r[i] <= ld_mrg;
      end
    end

    pit_chan_ctr u_ctr (
      .mclk(mclk),
      .rst_n(rst_n),
      .act(chan_act[i]),
      .tick(ch_tick),
      .force_ld(c_force[i]),
      .load_val(ld_r[i]),
      .cnt(cnt_w[i]),
      .timeout(tout[i])
    );
  end

  // ----------------------------------------------------------------
  // time-out flags
  // ----------------------------------------------------------------
  pit_ch_t flag_r;
  wire pit_ch_t flag_clr = {`PIT_NCH{we_flag}} & wdata_m[`PIT_NCH-1:0];
  wire pit_ch_t act_fall = chan_act & ~chan_act_nxt;
  wire pit_ch_t irq_fall = irqen_r & ~irqen_nxt;
  wire pit_ch_t flag_drop = flag_clr | act_fall | irq_fall;
  // set wins over clear and over enable drop
  wire pit_ch_t flag_nxt = (flag_r & ~flag_drop) | tout;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= `PIT_RST_CH;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // ----------------------------------------------------------------
  // triggers and interrupts
  // ----------------------------------------------------------------
  // one-cycle pulse on every time-out, in the cycle the flag is seen set
  pit_ch_t trig_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trig_r <= `PIT_RST_CH;
    end else begin
      trig_r <= tout;
    end
  end

  assign timeout_trigger_out = trig_r;
  assign channel_irq = flag_r & irqen_r;
  assign irq = |channel_irq;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  pit_word_t stat_rd;
  pit_word_t mld_acc [`PIT_NMT+1];
  pit_word_t chn_acc [`PIT_NCH+1];
  pit_word_t rd_word;
  pit_word_t rdata_r;

  wire pit_word_t stat_m_w = `PIT_DW'(m_act) << `PIT_STAT_MACT;
  wire pit_word_t stat_c_w = `PIT_DW'(chan_act) << `PIT_STAT_CACT;
  assign stat_rd = stat_m_w | stat_c_w;
  assign mld_acc[0] = `PIT_RST_WORD;
  assign chn_acc[0] = `PIT_RST_WORD;

  for (genvar j = 0; j < `PIT_NMT; j++) begin : g_rd_m
    assign mld_acc[j+1] = mld_acc[j] | ({`PIT_DW{hit_mld[j]}} & `PIT_DW'(mld_r[j]));
  end

  for (genvar i = 0; i < `PIT_NCH; i++) begin : g_rd_c
    wire pit_word_t ld_w = {`PIT_DW{hit_ld[i]}} & `PIT_DW'(ld_r[i]);
    wire pit_word_t cnt_rw = {`PIT_DW{hit_cnt[i]}} & `PIT_DW'(cnt_w[i]);
    assign chn_acc[i+1] = chn_acc[i] | ld_w | cnt_rw;
  end

  // force bits read back as zero
  assign rd_word = ({`PIT_DW{hit_ctrl}} & ctrl_rd)
                 | ({`PIT_DW{hit_chen}} & chen_rd)
                 | ({`PIT_DW{hit_mux}} & mux_rd)
                 | ({`PIT_DW{hit_irqen}} & irqen_rd)
                 | ({`PIT_DW{hit_flag}} & `PIT_DW'(flag_r))
                 | ({`PIT_DW{hit_stat}} & stat_rd)
                 | mld_acc[`PIT_NMT]
                 | chn_acc[`PIT_NCH];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= `PIT_RST_WORD;
    end else if (rd_cap) begin
      rdata_r <= rd_word;
    end
  end

  // captured in the wait cycle, shown in the ack cycle
  assign avs_readdata = rdata_r;

endmodule : pit_top
`default_nettype wire

//--- pit_sink.sv
`default_nettype none
`include "pit_regs.svh"
module pit_sink (
  // clock
  input wire logic mclk,
  // from timer
  input wire logic [`PIT_NCH-1:0] trig,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc;
  int irqs;
  int last [`PIT_NCH];
  int per [`PIT_NCH];
  int hits [`PIT_NCH];
  logic [`PIT_NCH-1:0] prev;
  // ------------------------------------------------------------
  // trigger consumer: cycles between rising edges
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    prev <= trig;
    if (irq === 1'b1) begin
      irqs <= irqs + 1;
    end
    for (int i = 0; i < `PIT_NCH; i++) begin
      if (trig[i] && !prev[i]) begin
        per[i] <= cyc - last[i];
        last[i] <= cyc;
        hits[i] <= hits[i] + 1;
      end
    end
  end
endmodule : pit_sink
`default_nettype wire

//--- pit_chk.sv
`default_nettype none
`include "pit_regs.svh"
module pit_chk import pit_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [`PIT_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [`PIT_DW-1:0] avs_writedata,
  input wire logic [`PIT_BEW-1:0] avs_byteenable,
  input wire logic [`PIT_DW-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // interrupts and triggers
  input wire logic irq,
  input wire logic [`PIT_NCH-1:0] channel_irq,
  input wire logic [`PIT_NCH-1:0] timeout_trigger_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire req = avs_read | avs_write;
  wire wr_ack = avs_write & !avs_waitrequest;
  wire rd_ack = avs_read & !avs_waitrequest;
  wire unmapped = (avs_address[1:0] != 2'h0) | (avs_address >= 8'h40);
  wire flag_wr = wr_ack & (avs_address == `PIT_OFF_FLAG) & avs_byteenable[0];
  wire ien_wr = wr_ack & (avs_address == `PIT_OFF_IRQEN);
  sequence s_answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  chk_one_wait: assert property ($rose(req) |-> s_answer)
    else $error("bus answer not after one wait state");
  chk_idle_nowait: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest high without a request");
  chk_irq_any: assert property (irq == (|channel_irq))
    else $error("irq differs from channel requests");
  chk_trig_single: assert property (|timeout_trigger_out |=>
    (timeout_trigger_out & $past(timeout_trigger_out)) == '0)
    else $error("trigger high for more than one cycle");
  chk_unmapped_zero: assert property (rd_ack && unmapped |-> avs_readdata == '0)
    else $error("unmapped read not zero");
  chk_force_rdzero: assert property (rd_ack && avs_address == `PIT_OFF_CTRL
    |-> avs_readdata[19:8] == '0)
    else $error("force bits read back nonzero");
  chk_flag_w1c: assert property (flag_wr |=>
    (channel_irq & $past(avs_writedata[3:0]) & ~timeout_trigger_out) == '0)
    else $error("flag not cleared by writing one");
  chk_flag_zero: assert property (flag_wr |=>
    ($past(channel_irq) & ~channel_irq & ~$past(avs_writedata[3:0])) == '0)
    else $error("flag cleared by writing zero");
  chk_flag_sticky: assert property (!wr_ack |=> ($past(channel_irq) & ~channel_irq) == '0)
    else $error("flag dropped without a write");
  chk_irq_cause: assert property (!ien_wr |=>
    (channel_irq & ~$past(channel_irq) & ~timeout_trigger_out) == '0)
    else $error("request rose without trigger");
endmodule : pit_chk
bind pit_top pit_chk u_chk (
  .mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
  .channel_irq(channel_irq), .timeout_trigger_out(timeout_trigger_out)
);
`default_nettype wire

//--- testbench.sv
`default_nettype none
`include "pit_regs.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module testbench import pit_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [`PIT_AW-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  pit_word_t avs_writedata = '0;
  logic [`PIT_BEW-1:0] avs_byteenable = '0;
  pit_word_t avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [`PIT_NCH-1:0] channel_irq;
  logic [`PIT_NCH-1:0] trig;
  int err_count = 0;
  int num_checks = 0;
  int seed = 22003;
  int cycles = 0;
  int mld [2];
  int ld [`PIT_NCH];
  logic [3:0] mux;
  pit_word_t q;
  pit_word_t q2;
  pit_top dut (.mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .channel_irq(channel_irq), .timeout_trigger_out(trig));
  pit_sink u_sink (.mclk(mclk), .trig(trig), .irq(irq));
  initial begin
    forever #5 mclk = ~mclk;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input pit_word_t d,
                     input logic [3:0] be, output pit_word_t rd);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input pit_word_t d);
    bus(1'b1, a, d, 4'hf, q);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [7:0] a, input pit_word_t e);
    bus(1'b0, a, 32'h0, 4'hf, q);
    `CHK(nm, e, q)
  endtask : rd_chk
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int a = 0; a < 'h40; a += 4) rd_chk("reset value", 8'(a), 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rd_chk("unmapped", 8'h40, 32'h0);
    rd_chk("unaligned", 8'h22, 32'h0);
    mux = 4'($random(seed));
    for (int m = 0; m < 2; m++) begin
      mld[m] = {$random(seed)} % 3 + 1;
      wr(`PIT_OFF_MLD0 + 8'(4 * m), 32'(mld[m]));
    end
    for (int i = 0; i < 4; i++) begin
      ld[i] = {$random(seed)} % 8 + 1;
      wr(`PIT_OFF_LD0 + 8'(4 * i), 32'(ld[i]));
    end
    wr(`PIT_OFF_MUX, 32'(mux));
    wr(`PIT_OFF_IRQEN, 32'hf);
    wr(`PIT_OFF_CHEN, 32'hf);
    wr(`PIT_OFF_CTRL, 32'h1);
    rd_chk("status", `PIT_OFF_STAT, {20'h0, 4'hf, 6'h0, mux != 4'h0, mux != 4'hf});
    repeat (300) @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      `CHK("period", (mld[mux[i]] + 1) * (ld[i] + 1), u_sink.per[i])
      `CHK("trigger edges", 1'b1, u_sink.hits[i] > 1)
    end
    rd_chk("flags set", `PIT_OFF_FLAG, 32'hf);
    `CHK("irq", 1'b1, irq)
    `CHK("irq seen", 1'b1, u_sink.irqs > 0)
    wr(`PIT_OFF_IRQEN, 32'h5);
    `CHK("masked", 4'h0, channel_irq & 4'ha)
    for (int i = 0; i < 4; i++) wr(`PIT_OFF_LD0 + 8'(4 * i), 32'h8000);
    repeat (300) @(posedge mclk);
    rd_chk("flags again", `PIT_OFF_FLAG, 32'hf);
    wr(`PIT_OFF_FLAG, 32'h0);
    rd_chk("zero write", `PIT_OFF_FLAG, 32'hf);
    bus(1'b1, `PIT_OFF_FLAG, 32'h5, 4'h2, q);
    rd_chk("lane masked", `PIT_OFF_FLAG, 32'hf);
    wr(`PIT_OFF_FLAG, 32'h5);
    rd_chk("one write", `PIT_OFF_FLAG, 32'ha);
    `CHK("irq cleared", 1'b0, irq)
    wr(`PIT_OFF_IRQEN, 32'hf);
    `CHK("channel irq", 4'ha, channel_irq)
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, `PIT_OFF_CNT0 + 8'(4 * i), 32'h0, 4'hf, q);
      `CHK("count range", 1'b1, q[15:0] <= 16'h8000 && q[15:0] > 16'h7e00)
    end
    repeat (600) @(posedge mclk);
    wr(`PIT_OFF_CTRL, 32'h000f_0301);
    bus(1'b0, `PIT_OFF_CNT0, 32'h0, 4'hf, q);
    `CHK("forced count", 16'h8000, q[15:0])
    rd_chk("ctrl", `PIT_OFF_CTRL, 32'h1);
    wr(`PIT_OFF_CHEN, 32'h3);
    rd_chk("chan off flags", `PIT_OFF_FLAG, 32'h2);
    bus(1'b0, `PIT_OFF_CNT0 + 8'h08, 32'h0, 4'hf, q2);
    repeat (20) @(posedge mclk);
    rd_chk("held count", `PIT_OFF_CNT0 + 8'h08, q2);
    wr(`PIT_OFF_CTRL, 32'h0);
    rd_chk("module off flags", `PIT_OFF_FLAG, 32'h0);
    `CHK("irq off", 1'b0, irq)
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
